// ==== shared/cttr_pkg.sv ====
/*
 * Constants, field layouts and carrier types of the compare timer with
 * start trigger and waveform output.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package cttr_pkg;

   // widths and default rates
   localparam int unsigned CNT_W     = 8;
   localparam int unsigned ADR_W     = 8;
   localparam int unsigned PRESCALE  = 4;

   // register byte offsets
   localparam logic [7:0] OFS_TEC    = 8'h00;
   localparam logic [7:0] OFS_OSEL   = 8'h04;
   localparam logic [7:0] OFS_MCA    = 8'h08;
   localparam logic [7:0] OFS_MCB    = 8'h0C;
   localparam logic [7:0] OFS_CNT    = 8'h10;
   localparam logic [7:0] OFS_STAT   = 8'h14;

   // trigger_edge_control layout
   localparam int unsigned TEC_RSV_LSB  = 5;
   localparam int unsigned TEC_EDGE_LSB = 3;
   localparam int unsigned TEC_EN_BIT   = 2;
   localparam int unsigned TEC_CLK_LSB  = 0;
   localparam logic [2:0]  TEC_RSV_VAL  = 3'h7;

   // output select layout
   localparam int unsigned OSEL_A_LSB = 0;
   localparam int unsigned OSEL_B_LSB = 2;

   // status layout
   localparam int unsigned STAT_WAVE = 0;
   localparam int unsigned STAT_RUN  = 1;

   // reset values
   localparam logic [CNT_W-1:0] MC_RST = 8'hFF;

   typedef enum logic [1:0] {
      ACT_KEEP   = 2'h0,
      ACT_LOW    = 2'h1,
      ACT_HIGH   = 2'h2,
      ACT_TOGGLE = 2'h3
   } cttr_act_t;

   typedef enum logic [1:0] {
      EDGE_OFF  = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } cttr_edge_t;

   typedef enum logic [1:0] {
      CSEL_STOP   = 2'h0,
      CSEL_PRESC  = 2'h1,
      CSEL_EV_R   = 2'h2,
      CSEL_EV_RF  = 2'h3
   } cttr_csel_t;

   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADR_W-1:0]  adr;
      logic [3:0]        sel;
      logic [31:0]       dat;
   } cttr_wb_req_t;

   typedef struct packed {
      cttr_edge_t edge_sel;
      logic       trig_en;
      cttr_csel_t clk_sel;
   } cttr_tec_t;

   typedef struct packed {
      cttr_act_t b;
      cttr_act_t a;
   } cttr_osel_t;

endpackage

// ==== hdl/cttr_timer.sv ====
/*
 * 8-bit compare-match timer with edge-selected start trigger, external
 * event clock, external counter clear and a compare-driven waveform pin.
 * Assumes one 50 MHz clock with synchronous active-high reset; the three
 * pins are asynchronous and are synchronised here.
 */
// Decided for this implementation: the Wishbone register port and the placing of the registers.
// Summary of operation
// - match A drives wave pin: 00 keep, 01 low, 10 high, 11 toggle.
// - separate 2-bit select sets the wave pin action on match B.
// - match A and match B actions are set independently.
// - wave pin is low after reset until the first compare match.
// - edge field selects trigger: 00 off, 01 rising, 10 falling, 11 both.
// - with trigger enabled, selected edge starts count; match-clear stops it.
// - with trigger disabled, neither trigger start nor match-clear stop applies.
// - top three bits of trigger_edge_control always read as one.
// - external count_clear_pin clears the counter.
// - external start_trigger_pin edges, qualified by edge field, start the count.
// - external event_clock_pin edges can serve as the count source.
// - dedicated wave_out_pin carries the compare-driven waveform.
module cttr_timer #(
   parameter int unsigned CNT_W    = cttr_pkg::CNT_W,
   parameter int unsigned PRESCALE = cttr_pkg::PRESCALE
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // register bus
   input  wire cttr_pkg::cttr_wb_req_t wb_req,
   output logic [31:0]               wb_dat_r,
   output logic                      wb_ack,
   // pins
   input  wire logic                 start_trigger_pin,
   input  wire logic                 event_clock_pin,
   input  wire logic                 count_clear_pin,
   output logic                      wave_out_pin
);

   // pin synchronisers: index 0 trigger, 1 event, 2 clear
   logic [2:0] pin_raw;
   logic [2:0] pin_s1_q;
   logic [2:0] pin_s2_q;
   logic [2:0] pin_s3_q;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;

   assign pin_raw = {count_clear_pin, event_clock_pin, start_trigger_pin};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               pin_s1_q[gi] <= 1'b0;
               pin_s2_q[gi] <= 1'b0;
               pin_s3_q[gi] <= 1'b0;
            end else begin
               pin_s1_q[gi] <= pin_raw[gi];
               pin_s2_q[gi] <= pin_s1_q[gi];
               pin_s3_q[gi] <= pin_s2_q[gi];
            end
         end
         assign pin_rise[gi] = pin_s2_q[gi] & ~pin_s3_q[gi];
         assign pin_fall[gi] = ~pin_s2_q[gi] & pin_s3_q[gi];
      end
   endgenerate

   // registers
   cttr_pkg::cttr_tec_t  tec_q;
   cttr_pkg::cttr_osel_t osel_q;
   logic [CNT_W-1:0]     mca_q;
   logic [CNT_W-1:0]     mcb_q;
   logic [CNT_W-1:0]     cnt_q;
   logic                 run_q;
   logic                 wave_q;
   logic                 ack_q;
   logic [31:0]          dat_r_q;

   // bus decode
   logic       req;
   logic       wr;
   logic       wr_lo;
   logic [31:0] rd_d;

   assign req   = wb_req.cyc & wb_req.stb & ~ack_q;
   assign wr    = req & wb_req.we;
   assign wr_lo = wr & wb_req.sel[0];

   always_comb begin
      rd_d = 32'h0000_0000;
      case (wb_req.adr)
         cttr_pkg::OFS_TEC: begin
            rd_d[cttr_pkg::TEC_RSV_LSB +: 3]  = cttr_pkg::TEC_RSV_VAL;
            rd_d[cttr_pkg::TEC_EDGE_LSB +: 2] = tec_q.edge_sel;
            rd_d[cttr_pkg::TEC_EN_BIT]        = tec_q.trig_en;
            rd_d[cttr_pkg::TEC_CLK_LSB +: 2]  = tec_q.clk_sel;
         end
         cttr_pkg::OFS_OSEL: begin
            rd_d[cttr_pkg::OSEL_A_LSB +: 2] = osel_q.a;
            rd_d[cttr_pkg::OSEL_B_LSB +: 2] = osel_q.b;
         end
         cttr_pkg::OFS_MCA:  rd_d[CNT_W-1:0] = mca_q;
         cttr_pkg::OFS_MCB:  rd_d[CNT_W-1:0] = mcb_q;
         cttr_pkg::OFS_CNT:  rd_d[CNT_W-1:0] = cnt_q;
         cttr_pkg::OFS_STAT: begin
            rd_d[cttr_pkg::STAT_WAVE] = wave_q;
            rd_d[cttr_pkg::STAT_RUN]  = run_q;
         end
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // one-cycle ack; unmapped addresses are acked and read as zero
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q   <= 1'b0;
         dat_r_q <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         if (req & ~wb_req.we) begin
            dat_r_q <= rd_d;
         end
      end
   end

   assign wb_ack   = ack_q;
   assign wb_dat_r = dat_r_q;

   // control register writes
   always_ff @(posedge clk) begin
      if (rst) begin
         tec_q  <= '{edge_sel: cttr_pkg::EDGE_OFF, trig_en: 1'b0,
                     clk_sel: cttr_pkg::CSEL_STOP};
         osel_q <= '{b: cttr_pkg::ACT_KEEP, a: cttr_pkg::ACT_KEEP};
         mca_q  <= cttr_pkg::MC_RST;
         mcb_q  <= cttr_pkg::MC_RST;
      end else if (wr_lo) begin
         case (wb_req.adr)
            cttr_pkg::OFS_TEC: begin
               tec_q.edge_sel <= cttr_pkg::cttr_edge_t'(wb_req.dat[cttr_pkg::TEC_EDGE_LSB +: 2]);
               tec_q.trig_en  <= wb_req.dat[cttr_pkg::TEC_EN_BIT];
               tec_q.clk_sel  <= cttr_pkg::cttr_csel_t'(wb_req.dat[cttr_pkg::TEC_CLK_LSB +: 2]);
            end
            cttr_pkg::OFS_OSEL: begin
               osel_q.a <= cttr_pkg::cttr_act_t'(wb_req.dat[cttr_pkg::OSEL_A_LSB +: 2]);
               osel_q.b <= cttr_pkg::cttr_act_t'(wb_req.dat[cttr_pkg::OSEL_B_LSB +: 2]);
            end
            cttr_pkg::OFS_MCA: mca_q <= wb_req.dat[CNT_W-1:0];
            cttr_pkg::OFS_MCB: mcb_q <= wb_req.dat[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   // internal count source: one-cycle enable every PRESCALE clocks
   localparam int unsigned PS_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
   logic [PS_W-1:0] ps_q;
   logic            ps_tick;

   assign ps_tick = (ps_q == PS_W'(PRESCALE - 1));

   always_ff @(posedge clk) begin
      if (rst || ps_tick) begin
         ps_q <= '0;
      end else begin
         ps_q <= ps_q + PS_W'(1);
      end
   end

   // count source and gating
   logic src;
   logic tick;
   logic trig_hit;
   logic clr_pin;
   logic cnt_wr;
   logic match_a;
   logic match_b;

   always_comb begin
      case (tec_q.clk_sel)
         cttr_pkg::CSEL_PRESC: src = ps_tick;
         cttr_pkg::CSEL_EV_R:  src = pin_rise[1];
         cttr_pkg::CSEL_EV_RF: src = pin_rise[1] | pin_fall[1];
         default:              src = 1'b0;
      endcase
   end

   assign tick     = src & run_q;
   // edge field bit 0 enables rising, bit 1 falling; 00 ignores the pin
   assign trig_hit = (tec_q.edge_sel[0] & pin_rise[0])
                   | (tec_q.edge_sel[1] & pin_fall[0]);
   assign clr_pin  = pin_rise[2];
   assign cnt_wr   = wr_lo & (wb_req.adr == cttr_pkg::OFS_CNT);

   // a match only counts on a tick, so a stopped counter cannot rematch
   assign match_a = tick & (cnt_q == mca_q);
   assign match_b = tick & (cnt_q == mcb_q);

   // counter: pin clear beats software write beats match clear
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (clr_pin) begin
         cnt_q <= '0;
      end else if (cnt_wr) begin
         cnt_q <= wb_req.dat[CNT_W-1:0];
      end else if (match_a) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // run gate: free running unless trigger start is enabled
   always_ff @(posedge clk) begin
      if (rst) begin
         run_q <= 1'b0;
      end else if (!tec_q.trig_en) begin
         run_q <= 1'b1;
      end else if (match_a) begin
         run_q <= 1'b0;
      end else if (trig_hit) begin
         run_q <= 1'b1;
      end
   end

   // waveform output
   function automatic logic apply_act(cttr_pkg::cttr_act_t act, logic cur);
      case (act)
         cttr_pkg::ACT_LOW:    apply_act = 1'b0;
         cttr_pkg::ACT_HIGH:   apply_act = 1'b1;
         cttr_pkg::ACT_TOGGLE: apply_act = ~cur;
         default:              apply_act = cur;
      endcase
   endfunction

   // match A takes priority when both constants hit on one tick
   always_ff @(posedge clk) begin
      if (rst) begin
         wave_q <= 1'b0;
      end else if (match_a) begin
         wave_q <= apply_act(osel_q.a, wave_q);
      end else if (match_b) begin
         wave_q <= apply_act(osel_q.b, wave_q);
      end
   end

   assign wave_out_pin = wave_q;

   // checks
   sequence s_match_a_with(cttr_pkg::cttr_act_t act);
      match_a && osel_q.a == act;
   endsequence

   sequence s_tec_read;
      req && !wb_req.we && wb_req.adr == cttr_pkg::OFS_TEC;
   endsequence

   chk_match_a_low: assert property (@(posedge clk) disable iff (rst)
      s_match_a_with(cttr_pkg::ACT_LOW) |=> !wave_out_pin)
      else $error("match A low action did not drive 0");

   chk_match_a_high: assert property (@(posedge clk) disable iff (rst)
      s_match_a_with(cttr_pkg::ACT_HIGH) |=> wave_out_pin)
      else $error("match A high action did not drive 1");

   chk_match_a_toggle: assert property (@(posedge clk) disable iff (rst)
      s_match_a_with(cttr_pkg::ACT_TOGGLE) |=> wave_out_pin != $past(wave_out_pin))
      else $error("match A toggle action did not toggle");

   chk_match_b_action: assert property (@(posedge clk) disable iff (rst)
      match_b && !match_a && osel_q.b == cttr_pkg::ACT_HIGH |=> wave_out_pin)
      else $error("match B high action did not drive 1");

   chk_act_independent: assert property (@(posedge clk) disable iff (rst)
      match_b && !match_a && osel_q.b == cttr_pkg::ACT_KEEP |=> $stable(wave_out_pin))
      else $error("match B keep action changed the pin");

   chk_reset_low: assert property (@(posedge clk)
      rst |=> !wave_out_pin)
      else $error("wave pin not low after reset");

   chk_trig_ignored: assert property (@(posedge clk) disable iff (rst)
      tec_q.trig_en && tec_q.edge_sel == cttr_pkg::EDGE_OFF && !run_q |=> !run_q)
      else $error("counter started with trigger disabled by edge field");

   chk_trig_start: assert property (@(posedge clk) disable iff (rst)
      tec_q.trig_en && !run_q && pin_s2_q[0] && !pin_s3_q[0]
      && tec_q.edge_sel[0] |=> run_q)
      else $error("rising trigger did not start the counter");

   chk_match_stop: assert property (@(posedge clk) disable iff (rst)
      tec_q.trig_en && match_a |=> !run_q && cnt_q == '0 || $past(clr_pin || cnt_wr))
      else $error("match clear did not stop the counter");

   chk_free_run: assert property (@(posedge clk) disable iff (rst)
      !tec_q.trig_en |=> run_q)
      else $error("counter gated while trigger start disabled");

   chk_rsv_read: assert property (@(posedge clk) disable iff (rst)
      s_tec_read |=> wb_ack && wb_dat_r[7:5] == 3'h7)
      else $error("reserved bits did not read as one");

   chk_pin_clear: assert property (@(posedge clk) disable iff (rst)
      pin_s2_q[2] && !pin_s3_q[2] |=> cnt_q == '0)
      else $error("clear pin did not clear the counter");

   chk_event_count: assert property (@(posedge clk) disable iff (rst)
      tick && !match_a && !clr_pin && !cnt_wr |=> cnt_q == $past(cnt_q) + CNT_W'(1))
      else $error("counter did not advance on its source");

endmodule

// ==== tb/cttr_pin_model.sv ====
/*
 * Far-side model of the timer pins: start trigger, event clock, count clear.
 * Assumes the caller runs on the timer clock; every level is held 4 clocks.
 */
module cttr_pin_model (
   // clock
   input  wire logic clk,
   // driven pins
   output logic      start_trigger_pin,
   output logic      event_clock_pin,
   output logic      count_clear_pin,
   // observed pin
   input  wire logic wave_out_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      start_trigger_pin = 1'b0;
      event_clock_pin   = 1'b0;
      count_clear_pin   = 1'b0;
   end

   // 4 clocks per level, well above the synchroniser's 1-clock minimum
   task automatic set_trg(input logic v);
      @(posedge clk);
      start_trigger_pin <= v;
      repeat (4) @(posedge clk);
   endtask

   task automatic ev_pulse();
      @(posedge clk);
      event_clock_pin <= 1'b1;
      repeat (4) @(posedge clk);
      event_clock_pin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic clr_pulse();
      @(posedge clk);
      count_clear_pin <= 1'b1;
      repeat (4) @(posedge clk);
      count_clear_pin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench of the compare timer: Wishbone tasks plus pin stimulus.
 * Assumes the pin model drives the three input pins of the timer.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic                   clk;
   logic                   rst;
   cttr_pkg::cttr_wb_req_t req;
   logic [31:0]            rdata;
   logic [31:0]            r;
   logic                   wb_ack;
   logic                   trg;
   logic                   evt;
   logic                   clr;
   logic                   wave;
   int                     failures;
   int                     n_compared;
   logic [1:0]             acts [5] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h3};
   logic [31:0]            waves [5] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h1};
   logic [7:0]             bacts [3] = '{8'h00, 8'h0C, 8'h08};
   logic [31:0]            bwaves [3] = '{32'h1, 32'h0, 32'h1};

   cttr_timer uut (
      .clk(clk), .rst(rst), .wb_req(req), .wb_dat_r(rdata), .wb_ack(wb_ack),
      .start_trigger_pin(trg), .event_clock_pin(evt), .count_clear_pin(clr),
      .wave_out_pin(wave));

   cttr_pin_model pins (
      .clk(clk), .start_trigger_pin(trg), .event_clock_pin(evt),
      .count_clear_pin(clr), .wave_out_pin(wave));

   task automatic stop_test();
      if (failures == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int i;
      @(posedge clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (wb_ack === 1'b1) break;
      end
      r = rdata;
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      if (i == 50) begin
         failures++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      xfer(1'b1, adr, {24'h0, d});
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] m, input logic [31:0] e, input string s);
      xfer(1'b0, adr, 32'h0);
      check(r & m, e, s);
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      req = '0;
      failures = 0;
      n_compared = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      check({31'h0, wave}, 32'h0, "wave after reset");
      rd(8'h00, 32'hFF, 32'hE0, "tec reset");
      rd(8'h08, 32'hFF, 32'hFF, "const a reset");
      rd(8'h0C, 32'hFF, 32'hFF, "const b reset");
      rd(8'h18, 32'hFFFFFFFF, 32'h0, "unmapped");
      wr(8'h00, 8'h1F);
      rd(8'h00, 32'hFF, 32'hFF, "tec all ones");
      wr(8'h00, 8'h02);
      rd(8'h00, 32'hFF, 32'hE2, "tec reserved");
      // free run on event edges, match A every second event
      wr(8'h08, 8'h01);
      wr(8'h10, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(8'h04, {6'h0, acts[k]});
         pins.ev_pulse();
         pins.ev_pulse();
         check({31'h0, wave}, waves[k], "match a action");
         rd(8'h10, 32'hFF, 32'h0, "match clears");
      end
      rd(8'h14, 32'h3, 32'h3, "no stop when disabled");
      // B drives low, A drives high, on one run
      wr(8'h08, 8'h03);
      wr(8'h0C, 8'h01);
      wr(8'h04, 8'h06);
      pins.ev_pulse();
      pins.ev_pulse();
      check({31'h0, wave}, 32'h0, "match b action");
      rd(8'h10, 32'hFF, 32'h2, "b does not clear");
      pins.ev_pulse();
      pins.ev_pulse();
      check({31'h0, wave}, 32'h1, "a independent of b");
      // B alone: keep, toggle, high; A keeps the level and clears the count
      for (int n = 0; n < 3; n++) begin
         wr(8'h04, bacts[n]);
         pins.ev_pulse();
         pins.ev_pulse();
         check({31'h0, wave}, bwaves[n], "match b action alone");
         pins.ev_pulse();
         pins.ev_pulse();
      end
      // reset in mid-run must bring the wave pin back low
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      check({31'h0, wave}, 32'h0, "wave after second reset");
      wr(8'h08, 8'h01);
      wr(8'h0C, 8'hFF);
      for (int m = 0; m < 4; m++) begin
         wr(8'h00, {3'h0, m[1:0], 3'h6});
         wr(8'h10, 8'h00);
         pins.ev_pulse();
         pins.ev_pulse();
         rd(8'h14, 32'h2, 32'h0, "stopped by match");
         pins.set_trg(1'b1);
         rd(8'h14, 32'h2, (m == 1 || m == 3) ? 32'h2 : 32'h0, "rise edge");
         pins.set_trg(1'b0);
         rd(8'h14, 32'h2, (m != 0) ? 32'h2 : 32'h0, "fall edge");
         pins.ev_pulse();
         rd(8'h10, 32'hFF, (m != 0) ? 32'h1 : 32'h0, "counts after start");
      end
      // internal source: any 40 clocks hold exactly 40 / PRESCALE ticks
      wr(8'h08, 8'hFF);
      wr(8'h00, 8'h01);
      wr(8'h10, 8'h00);
      repeat (38) @(posedge clk);
      rd(8'h10, 32'hFF, 32'(40 / cttr_pkg::PRESCALE), "prescaled count");
      wr(8'h00, 8'h00);
      wr(8'h10, 8'h37);
      rd(8'h10, 32'hFF, 32'h37, "counter write");
      pins.clr_pulse();
      rd(8'h10, 32'hFF, 32'h0, "clear pin");
      stop_test();
   end
endmodule
